// File: bmc_defs.vh
// bmc_defs.vh: offsets, field positions and reset values of the bias and monitor registers
// assumes inclusion by bare name from bmc_monitor_decode and bmc_regs; bmc_cal_count does not include it
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH

// --------------------------------------------------------------------------
// register map; offsets are word indexes, byte address is index times four
// --------------------------------------------------------------------------
`define BMC_IDX_BIAS        8'h08
`define BMC_IDX_MON         8'h09
`define BMC_ADDR_W          12
`define BMC_RST_BIAS        8'h00
`define BMC_RST_MON         8'h10
`define BMC_RST_CAL_CODE    2'h2
`define BMC_RST_CAL_SAMPLES 5'h08

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define BMC_BIAS_LEVEL_BIT  7
`define BMC_BIAS_PINS_MSB   6
`define BMC_MON_SEL_MSB     7
`define BMC_MON_SEL_LSB     5
`define BMC_CAL_MSB         4
`define BMC_CAL_LSB         3
`define BMC_TIMEOUT_BIT     2
`define BMC_CRC_BIT         1
`define BMC_STAT_BIT        0

// --------------------------------------------------------------------------
// monitor select codes
// --------------------------------------------------------------------------
`define BMC_MON_OFF         3'h0
`define BMC_MON_MID         3'h1
`define BMC_MON_TEMP        3'h2
`define BMC_MON_AVDIFF      3'h3
`define BMC_MON_DIGITAL     3'h4
`define BMC_MON_BO_LOW      3'h5
`define BMC_MON_BO_MID      3'h6
`define BMC_MON_BO_HIGH     3'h7

// --------------------------------------------------------------------------
// axi responses
// --------------------------------------------------------------------------
`define BMC_RESP_OKAY       2'h0
`define BMC_RESP_SLVERR     2'h2

`endif

// File: bmc_monitor_decode.v
// bmc_monitor_decode.v: turns the monitor select code into analog control strobes
// assumes a stable code from the register bank; purely combinational
`timescale 1ns/100ps
module bmc_monitor_decode
(
	input  wire [2:0] monitor_select_in,
	output reg        mid_short_out,
	output reg        temp_sensor_out,
	output reg        avdiff_mon_out,
	output reg        digital_supply_mon_out,
	output reg  [2:0] burnout_level_out,
	output wire       mux_open_out,
	output wire       force_gain_one_out
);
`include "bmc_defs.vh"

	always @*
	begin
		mid_short_out     = 1'b0;
		temp_sensor_out   = 1'b0;
		avdiff_mon_out    = 1'b0;
		digital_supply_mon_out = 1'b0;
		burnout_level_out = 3'h0;
		case (monitor_select_in)
			`BMC_MON_OFF:     mid_short_out     = 1'b0;
			`BMC_MON_MID:     mid_short_out     = 1'b1;
			`BMC_MON_TEMP:    temp_sensor_out   = 1'b1;
			`BMC_MON_AVDIFF:  avdiff_mon_out    = 1'b1;
			`BMC_MON_DIGITAL: digital_supply_mon_out = 1'b1;
			`BMC_MON_BO_LOW:  burnout_level_out = 3'h1;
			`BMC_MON_BO_MID:  burnout_level_out = 3'h2;
			`BMC_MON_BO_HIGH: burnout_level_out = 3'h4;
			default:          burnout_level_out = 3'h0;
		endcase
	end

	// switches open for every internal measurement
	assign mux_open_out       = mid_short_out | temp_sensor_out |
		avdiff_mon_out | digital_supply_mon_out;
	// supply monitors override the programmed gain
	assign force_gain_one_out = avdiff_mon_out | digital_supply_mon_out;
endmodule

// File: bmc_cal_count.v
// bmc_cal_count.v: maps the calibration averaging code to a sample count
// assumes the code comes straight from the control register
`timescale 1ns/100ps
module bmc_cal_count
(
	input  wire [1:0] calibration_average_count_in,
	output reg  [4:0] cal_samples_out
);
	always @*
	begin
		case (calibration_average_count_in)
			2'h0:    cal_samples_out = 5'h01;
			2'h1:    cal_samples_out = 5'h04;
			2'h2:    cal_samples_out = 5'h08;
			2'h3:    cal_samples_out = 5'h10;
			default: cal_samples_out = 5'h08;
		endcase
	end
endmodule

// File: bmc_regs.v
// bmc_regs.v: bias selection and monitor/framing control registers on an axi4-lite slave
// assumes one clock, an asynchronous active-low reset and a well-behaved axi4-lite master
//
// Functional notes
// - bias register at index 08h, read/write, resets to 00h
// - bias bit 7 picks mid-supply (0) or one twelfth supply sum (1)
// - bias source is off unless at least one pin bit is set
// - bits 6..0 connect bias to common input and inputs 5..0
// - pin bits act independently, any number may be on together
// - control register at index 09h, read/write, resets to 10h
// - monitor code 000 off; 001 shorts amplifier inputs to mid-supply
// - code 010 temperature sensor; software also sets amplifier enable to 01
// - code 011 analog supply/4, 100 digital supply/4, gain forced to 1
// - codes 101, 110, 111 enable burn-out sources 0.2, 1, 10 uA
// - bits 4:3 pick calibration averaging 1, 4, 8 or 16 samples
// - bit 2 enables serial timeout, cleared after reset
// - bit 1 appends crc over result, plus status byte when enabled
// - bit 0 prepends a status byte, off by default
// - internal measurements hold the input multiplexer switches open
// - supply monitors force amplifier gain to 1 regardless of setting
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
module bmc_regs
(
	input  wire        clock_in,
	input  wire        arst_n_in,
	// axi4-lite slave
	input  wire [11:0] s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output wire        s_axi_awready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output wire        s_axi_wready_out,
	output wire [1:0]  s_axi_bresp_out,
	output wire        s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	input  wire [11:0] s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output wire        s_axi_arready_out,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0]  s_axi_rresp_out,
	output wire        s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// bias controls
	output wire        bias_voltage_output_out,
	output wire        bias_level_select_out,
	output wire [6:0]  bias_pin_connect_out,
	// monitor controls
	output wire [2:0]  monitor_select_out,
	output wire        mid_short_out,
	output wire        temp_sensor_out,
	output wire        avdiff_mon_out,
	output wire        digital_supply_mon_out,
	output wire [2:0]  burnout_level_out,
	output wire        mux_open_out,
	output wire        force_gain_one_out,
	output wire [1:0]  calibration_average_count_out,
	output wire [4:0]  cal_samples_out,
	output wire        timeout_enable_out,
	output wire        crc_append_enable_out,
	output wire        crc_covers_status_out,
	output wire        status_prefix_enable_out
);
`include "bmc_defs.vh"

	// --------------------------------------------------------------------------
	// decode helper
	// --------------------------------------------------------------------------
	// 0 = bias, 1 = control, 2 = unmapped
	function [1:0] reg_sel;
		input [11:0] addr;
		begin
			if (addr[1:0] != 2'h0)
				reg_sel = 2'h2;
			else if (addr[11:2] == {2'h0, `BMC_IDX_BIAS})
				reg_sel = 2'h0;
			else if (addr[11:2] == {2'h0, `BMC_IDX_MON})
				reg_sel = 2'h1;
			else
				reg_sel = 2'h2;
		end
	endfunction

	// --------------------------------------------------------------------------
	// state
	// --------------------------------------------------------------------------
	reg  [7:0]  bias_reg;
	reg  [7:0]  mon_reg;
	reg  [11:0] awaddr_reg;
	reg         aw_full_reg;
	reg  [7:0]  wdata_reg;
	reg         wbyte_reg;
	reg         w_full_reg;
	reg         bvalid_reg;
	reg  [1:0]  bresp_reg;
	reg         rvalid_reg;
	reg  [1:0]  rresp_reg;
	reg  [31:0] rdata_reg;
	reg         bias_level_reg;
	reg  [6:0]  bias_pins_reg;
	reg         bias_on_reg;
	reg  [2:0]  mon_sel_reg;
	reg  [3:0]  strobe_reg;
	reg  [2:0]  burnout_reg;
	reg         mux_open_reg;
	reg         gain_one_reg;
	reg  [1:0]  cal_code_reg;
	reg  [4:0]  cal_samples_reg;
	reg  [3:0]  frame_reg;

	wire        do_write;
	wire [1:0]  wsel;
	wire [1:0]  rsel;
	wire [2:0]  mon_sel;
	wire [1:0]  cal_code;
	wire [3:0]  frame_next;
	wire        mid_short;
	wire        temp_sense;
	wire        avdiff_mon;
	wire        digital_mon;
	wire [2:0]  burnout_level;
	wire        mux_open;
	wire        force_gain_one;
	wire [4:0]  cal_samples;

	// address and data are each latched once; write fires when both are held
	assign s_axi_awready_out = ~aw_full_reg & ~bvalid_reg;
	assign s_axi_wready_out  = ~w_full_reg & ~bvalid_reg;
	assign do_write          = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wsel              = reg_sel(awaddr_reg);
	assign s_axi_bvalid_out  = bvalid_reg;
	assign s_axi_bresp_out   = bresp_reg;

	assign s_axi_arready_out = ~rvalid_reg;
	assign rsel              = reg_sel(s_axi_araddr_in);
	assign s_axi_rvalid_out  = rvalid_reg;
	assign s_axi_rdata_out   = rdata_reg;
	assign s_axi_rresp_out   = rresp_reg;

	// --------------------------------------------------------------------------
	// write channel
	// --------------------------------------------------------------------------
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			awaddr_reg  <= 12'h000;
			aw_full_reg <= 1'b0;
			wdata_reg   <= 8'h00;
			wbyte_reg   <= 1'b0;
			w_full_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `BMC_RESP_OKAY;
			bias_reg    <= `BMC_RST_BIAS;
			mon_reg     <= `BMC_RST_MON;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				awaddr_reg  <= s_axi_awaddr_in;
				aw_full_reg <= 1'b1;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				wdata_reg  <= s_axi_wdata_in[7:0];
				wbyte_reg  <= s_axi_wstrb_in[0];
				w_full_reg <= 1'b1;
			end
			if (do_write)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (wsel == 2'h2) ? `BMC_RESP_SLVERR : `BMC_RESP_OKAY;
				// only byte lane 0 carries register bits
				if (wbyte_reg && wsel == 2'h0)
					bias_reg <= wdata_reg;
				if (wbyte_reg && wsel == 2'h1)
					mon_reg <= wdata_reg;
			end
			else if (bvalid_reg && s_axi_bready_in)
				bvalid_reg <= 1'b0;
		end
	end

	// --------------------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------------------
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `BMC_RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			rvalid_reg <= 1'b1;
			// reads only sample, nothing changes as a result
			case (rsel)
				2'h0:
				begin
					rdata_reg <= {24'h000000, bias_reg};
					rresp_reg <= `BMC_RESP_OKAY;
				end
				2'h1:
				begin
					rdata_reg <= {24'h000000, mon_reg};
					rresp_reg <= `BMC_RESP_OKAY;
				end
				default:
				begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= `BMC_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready_in)
			rvalid_reg <= 1'b0;
	end

	// --------------------------------------------------------------------------
	// bias controls
	// --------------------------------------------------------------------------
	// flopped so the analog switches never see a decode glitch; costs one cycle of latency
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			bias_level_reg <= 1'b0;
			bias_pins_reg  <= 7'h00;
			bias_on_reg    <= 1'b0;
		end
		else
		begin
			bias_level_reg <= bias_reg[`BMC_BIAS_LEVEL_BIT];
			bias_pins_reg  <= bias_reg[`BMC_BIAS_PINS_MSB:0];
			// source draws no power when no pin needs it
			bias_on_reg    <= |bias_reg[`BMC_BIAS_PINS_MSB:0];
		end
	end

	assign bias_level_select_out   = bias_level_reg;
	assign bias_pin_connect_out    = bias_pins_reg;
	assign bias_voltage_output_out = bias_on_reg;

	// --------------------------------------------------------------------------
	// monitor and framing controls
	// --------------------------------------------------------------------------
	assign mon_sel    = mon_reg[`BMC_MON_SEL_MSB:`BMC_MON_SEL_LSB];
	assign cal_code   = mon_reg[`BMC_CAL_MSB:`BMC_CAL_LSB];
	// crc range widens to the status byte only when it is sent
	assign frame_next = {mon_reg[`BMC_TIMEOUT_BIT], mon_reg[`BMC_CRC_BIT],
		mon_reg[`BMC_CRC_BIT] & mon_reg[`BMC_STAT_BIT], mon_reg[`BMC_STAT_BIT]};

	bmc_monitor_decode u_mon
	(
		.monitor_select_in      (mon_sel),
		.mid_short_out          (mid_short),
		.temp_sensor_out        (temp_sense),
		.avdiff_mon_out         (avdiff_mon),
		.digital_supply_mon_out (digital_mon),
		.burnout_level_out      (burnout_level),
		.mux_open_out           (mux_open),
		.force_gain_one_out     (force_gain_one)
	);

	bmc_cal_count u_cal
	(
		.calibration_average_count_in (cal_code),
		.cal_samples_out              (cal_samples)
	);

	// every decoded control leaves from a flop, all moving on the same edge
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			mon_sel_reg     <= `BMC_MON_OFF;
			strobe_reg      <= 4'h0;
			burnout_reg     <= 3'h0;
			mux_open_reg    <= 1'b0;
			gain_one_reg    <= 1'b0;
			cal_code_reg    <= `BMC_RST_CAL_CODE;
			cal_samples_reg <= `BMC_RST_CAL_SAMPLES;
			frame_reg       <= 4'h0;
		end
		else
		begin
			mon_sel_reg     <= mon_sel;
			strobe_reg      <= {mid_short, temp_sense, avdiff_mon, digital_mon};
			burnout_reg     <= burnout_level;
			mux_open_reg    <= mux_open;
			gain_one_reg    <= force_gain_one;
			cal_code_reg    <= cal_code;
			cal_samples_reg <= cal_samples;
			frame_reg       <= frame_next;
		end
	end

	assign monitor_select_out            = mon_sel_reg;
	assign mid_short_out                 = strobe_reg[3];
	assign temp_sensor_out               = strobe_reg[2];
	assign avdiff_mon_out                = strobe_reg[1];
	assign digital_supply_mon_out        = strobe_reg[0];
	assign burnout_level_out             = burnout_reg;
	assign mux_open_out                  = mux_open_reg;
	assign force_gain_one_out            = gain_one_reg;
	assign calibration_average_count_out = cal_code_reg;
	assign cal_samples_out               = cal_samples_reg;
	assign timeout_enable_out            = frame_reg[3];
	assign crc_append_enable_out         = frame_reg[2];
	assign crc_covers_status_out         = frame_reg[1];
	assign status_prefix_enable_out      = frame_reg[0];
endmodule

// File: bmc_regs_monitor.sv
// bmc_regs_monitor.sv: port-level checks for the bias and monitor register bank
// assumes it is bound into bmc_regs, with one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module bmc_regs_checker
(
	input logic        clock_in,
	input logic        arst_n_in,
	input logic        s_axi_awvalid_in,
	input logic        s_axi_awready_out,
	input logic        s_axi_wvalid_in,
	input logic        s_axi_wready_out,
	input logic        s_axi_bvalid_out,
	input logic        s_axi_arvalid_in,
	input logic        s_axi_arready_out,
	input logic        s_axi_rvalid_out,
	input logic        s_axi_rready_in,
	input logic [31:0] s_axi_rdata_out,
	input logic        bias_voltage_output_out,
	input logic [6:0]  bias_pin_connect_out,
	input logic [2:0]  monitor_select_out,
	input logic        mid_short_out,
	input logic        temp_sensor_out,
	input logic [2:0]  burnout_level_out,
	input logic        mux_open_out,
	input logic        force_gain_one_out,
	input logic [1:0]  calibration_average_count_out,
	input logic [4:0]  cal_samples_out
);
	wire [2:0] sel = monitor_select_out;
	wire [1:0] cal = calibration_average_count_out;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);
	// --------------------------------------------------------------------------
	// write channel
	// --------------------------------------------------------------------------
	sequence s_wr_take;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_wr_answer;
		!s_axi_bvalid_out ##1 s_axi_bvalid_out;
	endsequence
	property p_wr_answer;
		s_wr_take |=> s_wr_answer;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
	// --------------------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------------------
	sequence s_rd_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	sequence s_rd_stall;
		s_axi_rvalid_out && !s_axi_rready_in;
	endsequence
	property p_rd_answer;
		s_rd_take |=> s_axi_rvalid_out;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
	property p_rd_hold;
		s_rd_stall |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved while stalled");
	// --------------------------------------------------------------------------
	// decoded controls
	// --------------------------------------------------------------------------
	property p_bias_on;
		bias_voltage_output_out == (bias_pin_connect_out != 7'h00);
	endproperty
	a_bias_on: assert property (p_bias_on) else $error("bias source enable wrong");
	property p_mux_open;
		mux_open_out == (sel >= 3'h1 && sel <= 3'h4);
	endproperty
	a_mux_open: assert property (p_mux_open) else $error("mux open wrong");
	property p_gain_one;
		force_gain_one_out == (sel == 3'h3 || sel == 3'h4);
	endproperty
	a_gain_one: assert property (p_gain_one) else $error("gain force wrong");
	property p_burnout;
		burnout_level_out == (sel == 3'h5 ? 3'h1 : sel == 3'h6 ? 3'h2 : sel == 3'h7 ? 3'h4 : 3'h0);
	endproperty
	a_burnout: assert property (p_burnout) else $error("burn-out level wrong");
	property p_cal;
		cal_samples_out == (cal == 2'h0 ? 5'h01 : cal == 2'h1 ? 5'h04 : cal == 2'h2 ? 5'h08 : 5'h10);
	endproperty
	a_cal: assert property (p_cal) else $error("calibration count wrong");
	property p_strobe;
		{mid_short_out, temp_sensor_out} == {sel == 3'h1, sel == 3'h2};
	endproperty
	a_strobe: assert property (p_strobe) else $error("monitor strobe wrong");
endmodule
bind bmc_regs bmc_regs_checker u_bmc_chk (.*);

// File: testbench.sv
// testbench.sv: axi4-lite driven checks of the bias and monitor register bank
// assumes bmc_regs and its bound checker are compiled before this file
`timescale 1ns/100ps
module testbench;
	logic clock_in = 1'b0, arst_n_in = 1'b0;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'h0;
	wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	wire [1:0] s_axi_bresp_out, s_axi_rresp_out, calibration_average_count_out;
	wire [31:0] s_axi_rdata_out;
	wire bias_voltage_output_out, bias_level_select_out, mid_short_out, temp_sensor_out;
	wire avdiff_mon_out, digital_supply_mon_out, mux_open_out, force_gain_one_out;
	wire timeout_enable_out;
	wire crc_append_enable_out, crc_covers_status_out, status_prefix_enable_out;
	wire [6:0] bias_pin_connect_out;
	wire [2:0] monitor_select_out, burnout_level_out;
	wire [4:0] cal_samples_out;
	int bad_count = 0, check_count = 0, cycles = 0, i, m;
	logic [7:0] d;
	bmc_regs dut (.*);
	always #5 clock_in = ~clock_in;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// upper data lanes carry junk on purpose: only lane 0 may land
	task wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, input logic [1:0] er);
		@(posedge clock_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'ha5a5a5, v};
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do
		begin
			@(posedge clock_in);
			if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'b0;
		chk(s_axi_bresp_out, er);
		#1;
	endtask
	// slow reads hold rready low until the answer shows, exercising the stall path
	task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er, input logic slow);
		@(posedge clock_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= !slow;
		do
		begin
			@(posedge clock_in);
			if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out && !s_axi_rready_in) s_axi_rready_in <= 1'b1;
		end while (!(s_axi_rvalid_out && s_axi_rready_in));
		s_axi_rready_in <= 1'b0;
		chk(s_axi_rdata_out, {24'h0, e});
		chk(s_axi_rresp_out, er);
	endtask
	task reset_values;
		rd(12'h020, 8'h00, 2'h0, 1'b1);
		rd(12'h024, 8'h10, 2'h0, 1'b0);
		chk({cal_samples_out, timeout_enable_out, crc_append_enable_out}, {5'h08, 2'h0});
		chk({status_prefix_enable_out, bias_voltage_output_out}, 2'h0);
	endtask
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			end_of_test;
		end
	end
	initial
	begin
		repeat (8) @(posedge clock_in);
		arst_n_in <= 1'b1;
		reset_values;
		for (i = 0; i < 10; i++)
		begin
			d = i < 8 ? 8'h01 << i : (i == 8 ? 8'h7f : 8'hd5);
			wr(12'h020, d, 4'hf, 2'h0);
			chk({bias_level_select_out, bias_pin_connect_out}, d);
			chk(bias_voltage_output_out, |d[6:0]);
			rd(12'h020, d, 2'h0, i[0]);
		end
		for (m = 0; m < 8; m++)
		begin
			d = {m[2:0], m[1:0], m[2:0]};
			wr(12'h024, d, 4'h1, 2'h0);
			rd(12'h024, d, 2'h0, m[0]);
			chk(monitor_select_out, m);
			chk({mid_short_out, temp_sensor_out}, {m == 1, m == 2});
			chk({avdiff_mon_out, digital_supply_mon_out}, {m == 3, m == 4});
			chk(mux_open_out, m >= 1 && m <= 4);
			chk(force_gain_one_out, m == 3 || m == 4);
			chk(burnout_level_out, m >= 5 ? 1 << (m - 5) : 0);
			chk(cal_samples_out, m[1:0] == 0 ? 1 : 4 << (m[1:0] - 1));
			chk(calibration_average_count_out, m[1:0]);
			chk({timeout_enable_out, crc_append_enable_out, status_prefix_enable_out}, m[2:0]);
			chk(crc_covers_status_out, m[1] & m[0]);
		end
		wr(12'h028, 8'h33, 4'hf, 2'h2);
		wr(12'h021, 8'h44, 4'hf, 2'h2);
		wr(12'h020, 8'h55, 4'he, 2'h0);
		rd(12'h020, 8'hd5, 2'h0, 1'b0);
		rd(12'h028, 8'h00, 2'h2, 1'b1);
		rd(12'h024, 8'hff, 2'h0, 1'b0);
		@(posedge clock_in);
		arst_n_in <= 1'b0;
		@(posedge clock_in);
		arst_n_in <= 1'b1;
		reset_values;
		end_of_test;
	end
endmodule
